//--- hw/rsqd_pkg.sv
/*
 * constants, field types and helpers for the receive signal quality block.
 * assumes one system clock at 100 MHz and an active-low asynchronous reset.
 */
// =====================================================================
// Summary of operation
// R1 - digital logic runs from the single crystal-derived system clock
// R2 - pass-through mode drives demodulated bits onto one selected output pin of three
// R3 - packet mode assembles bits into bytes, buffers them for the controller
// R4 - reset clears the whole block; controller then reprograms its configuration
// R5 - when enabled, the sleep timer on the slow tick wakes the chip periodically
// R6 - sleep interval programmable from one slow tick up to its documented maximum
// R7 - slow oscillator is measured at reset and periodically, flagged when within one percent
// R8 - battery sample taken on each move from sleep or standby into synth, rx, tx
// R9 - three-bit field sets smoothing filter order after the averaging stage
// R10 - filtered strength readable as raw code and as converted dBm value
// R11 - two-bit field selects live strength or capture at each packet stage
// R12 - compare flag is one when strength exceeds threshold, else zero
// R13 - compare flag routes to signal-valid interrupt or super-low-power rx control
// R14 - jump detector runs during FSK and counts each bit transition as one jump
// R15 - two-bit window field sets jumps needed before a judgement
// R16 - controller should choose four jumps; fewer only for short receive windows
// R17 - judgement is one only with matching rate, error in limit and SNR above 7 dB
// R18 - jump judgement routes to signal-valid interrupt or super-low-power rx control
// R19 - in direct mode with mute set, output is silenced by jump judgement
// R20 - battery result holds until the next tuning event replaces it
package rsqd_pkg;
	// =====================================================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int LP_PERIOD_NS = 31250;
	localparam logic [11:0] LP_DIV_NOM = 12'(LP_PERIOD_NS / CLK_PERIOD_NS);
	localparam logic [11:0] LP_TOL = 12'(LP_PERIOD_NS / CLK_PERIOD_NS / 100);
	localparam logic [30:0] SLEEP_TICKS_MIN = 31'h0000_0001;
	// =====================================================================
	// chip operating state codes
	localparam logic [3:0] ST_IDLE = 4'h0;
	localparam logic [3:0] ST_SLEEP = 4'h1;
	localparam logic [3:0] ST_STANDBY_STATE = 4'h2;
	localparam logic [3:0] ST_RFS = 4'h3;
	localparam logic [3:0] ST_RX = 4'h4;
	localparam logic [3:0] ST_TFS = 4'h5;
	localparam logic [3:0] ST_TX = 4'h6;
	// =====================================================================
	// field codes and reset values
	localparam logic [1:0] CAP_REALTIME = 2'h0;
	localparam logic [1:0] CAP_PKT_STAGE = 2'h1;
	localparam logic ROUTE_IRQ = 1'h0;
	localparam logic ROUTE_SLP = 1'h1;
	localparam logic [7:0] SNR_MIN_DB = 8'h07;
	localparam logic [7:0] DBM_OFFSET = 8'h80;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [15:0] ACC_RST = 16'h0000;
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 16;

	typedef struct packed {
		logic [2:0] smooth_order;
		logic [1:0] capture_select;
		logic [7:0] threshold;
		logic route;
	} rsqd_rssi_cfg_t;

	typedef struct packed {
		logic [1:0] window_select;
		logic [7:0] symbol_len;
		logic route;
	} rsqd_pjd_cfg_t;

	// jumps needed per window code: 2, 4, 8, 16
	function automatic logic [4:0] jump_target(input logic [1:0] sel);
		jump_target = 5'h02 << sel;
	endfunction

	function automatic logic is_tuned_state(input logic [3:0] st);
		is_tuned_state = (st == ST_RFS) || (st == ST_RX) || (st == ST_TFS) || (st == ST_TX);
	endfunction
endpackage

//--- hw/rsqd_rx_quality.sv
/*
 * receive-side digital logic: data routing, packet byte buffer, strength
 * filter and compare, phase-jump detector, sleep timer, battery capture.
 * assumes every input is synchronous to clk_sys and the demodulator marks
 * each bit sample with demod_valid.
 */
`timescale 1ns/1ps

// =====================================================================
// byte buffer
module rsqd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys, // system clock
	input wire logic resetn, // async reset, low
	input wire logic [WIDTH-1:0] in_data, // write data
	input wire logic in_valid, // write request
	output logic in_ready, // space left
	output logic [WIDTH-1:0] out_data, // head word
	output logic out_valid, // not empty
	input wire logic out_ready // reader takes head
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ff, rd_ff;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	// extra pointer bit tells full from empty
	assign in_ready = !((wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]));
	assign out_valid = (wr_ff != rd_ff);
	assign out_data = mem[rd_ff[AW-1:0]];
	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem[wr_ff[AW-1:0]] <= in_data;
	end
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_ff <= '0;
			rd_ff <= '0;
		end
		else
		begin
			wr_ff <= wr_ff + (AW+1)'(push);
			rd_ff <= rd_ff + (AW+1)'(pop);
		end
	end
	a_fifo_no_overrun: assert property (@(posedge clk_sys) disable iff (!resetn)
		!in_ready |=> wr_ff == $past(wr_ff)) else $error("fifo written while full"); // [R3]
endmodule

// =====================================================================
// top
module rsqd_rx_quality #(
	parameter logic [30:0] SLEEP_TICKS_MAX = 31'h4FF6_0000,
	parameter int CAL_EVERY = 16
) (
	input wire logic clk_sys, // system clock
	input wire logic resetn, // power-on reset, low
	input wire logic demod_bit, // demodulated bit
	input wire logic demod_valid, // bit sample strobe
	input wire logic fsk_active, // FSK demodulation on
	input wire logic pass_through, // 1 direct mode, 0 packet mode
	input wire logic [1:0] dout_sel, // output pin 1..3, 0 none
	input wire logic dout_mute, // mute direct output by jump result
	output logic [2:0] gpio_out, // pin data
	output logic [2:0] gpio_oe, // pin drive enable
	output logic [7:0] pkt_data, // buffered byte
	output logic pkt_valid, // byte available
	input wire logic pkt_ready, // controller takes byte
	output logic pkt_overflow, // sticky byte loss
	input wire logic pkt_overflow_clr, // clear loss flag
	input wire logic [3:0] chip_state, // operating state code
	input wire logic [7:0] battery_sample, // battery measurement
	output logic [7:0] battery_level_result, // last battery result
	input wire logic sleep_timer_en, // periodic wake enable
	input wire logic [30:0] sleep_ticks, // interval in slow ticks
	input wire logic in_sleep, // chip asleep
	output logic wake_pulse, // wake request pulse
	input wire logic low_power_oscillator_tick, // slow oscillator edge pulse
	output logic low_power_oscillator_cal_done, // measurement valid
	output logic low_power_oscillator_in_tol, // within one percent
	input wire logic [7:0] rssi_adc, // strength sample
	input wire logic rssi_adc_valid, // sample strobe
	input wire rsqd_pkg::rsqd_rssi_cfg_t rssi_cfg, // strength settings
	input wire logic pkt_stage, // packet stage pulse
	output logic [7:0] strength_raw_code, // filtered code
	output logic [7:0] strength_in_dbm, // code in dBm
	output logic strength_above, // above threshold
	input wire rsqd_pkg::rsqd_pjd_cfg_t pjd_cfg, // jump detector settings
	input wire logic demod_err_ok, // error within limit
	input wire logic [7:0] snr_db, // SNR estimate in dB
	output logic phase_jump_detector, // jump judgement
	output logic signal_valid_irq, // routed valid event
	output logic super_low_power_rx // routed slp control
);
	// =====================================================================
	// direct output and mute
	logic dout_ff;
	wire dout_nxt = demod_bit && !(dout_mute && !phase_jump_detector); // [R19]
	// shift in four bits so pin three is not lost to a three-bit overflow
	wire [2:0] sel_mask = pass_through ? 3'((4'h1 << dout_sel) >> 1) : 3'h0; // [R2]
	assign gpio_oe = sel_mask;
	assign gpio_out = sel_mask & {3{dout_ff}};
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			dout_ff <= 1'b0; // [R4]
		else if (demod_valid && pass_through)
			dout_ff <= dout_nxt;
	end

	// =====================================================================
	// packet byte assembly, msb first; a byte waits while the buffer is full
	localparam logic [7:0] BYTE_RST_W = rsqd_pkg::BYTE_RST;
	logic [7:0] shift_ff, hold_ff;
	logic [2:0] bitcnt_ff;
	logic hold_vld_ff, ovf_ff;
	logic fifo_in_ready;
	wire bit_in = demod_valid && !pass_through;
	wire byte_done = bit_in && (bitcnt_ff == 3'h7);
	wire [7:0] nxt_shift = {shift_ff[6:0], demod_bit};
	wire hold_free = !hold_vld_ff || fifo_in_ready;
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			shift_ff <= BYTE_RST_W;
			hold_ff <= BYTE_RST_W;
			bitcnt_ff <= 3'h0;
			hold_vld_ff <= 1'b0;
			ovf_ff <= 1'b0;
		end
		else
		begin
			if (bit_in)
			begin
				shift_ff <= nxt_shift; // [R3]
				bitcnt_ff <= bitcnt_ff + 3'h1;
			end
			if (byte_done && hold_free)
				hold_ff <= nxt_shift;
			if (byte_done && hold_free)
				hold_vld_ff <= 1'b1;
			else if (fifo_in_ready)
				hold_vld_ff <= 1'b0;
			// a loss in the clearing cycle still sets the flag
			ovf_ff <= (byte_done && !hold_free) || (ovf_ff && !pkt_overflow_clr);
		end
	end
	assign pkt_overflow = ovf_ff;
	rsqd_fifo #(.WIDTH(rsqd_pkg::FIFO_WIDTH), .DEPTH(rsqd_pkg::FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.in_data(hold_ff),
		.in_valid(hold_vld_ff),
		.in_ready(fifo_in_ready),
		.out_data(pkt_data),
		.out_valid(pkt_valid),
		.out_ready(pkt_ready)
	);

	// =====================================================================
	// low battery capture on each move from sleep or standby into a tuned state
	logic [3:0] prev_state_ff;
	logic [7:0] lbd_ff;
	wire from_idle_side = (prev_state_ff == rsqd_pkg::ST_SLEEP) || (prev_state_ff == rsqd_pkg::ST_STANDBY_STATE);
	wire tune_evt = from_idle_side && rsqd_pkg::is_tuned_state(chip_state); // [R8]
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			prev_state_ff <= rsqd_pkg::ST_IDLE;
			lbd_ff <= BYTE_RST_W;
		end
		else
		begin
			prev_state_ff <= chip_state;
			if (tune_evt)
				lbd_ff <= battery_sample; // [R20]
		end
	end
	assign battery_level_result = lbd_ff;

	// =====================================================================
	// slow oscillator measurement: system cycles between two slow edges
	typedef enum logic [2:0] {
		CAL_ARM = 3'b001,
		CAL_MEAS = 3'b010,
		CAL_HOLD = 3'b100
	} rsqd_cal_t;
	rsqd_cal_t cal_ff;
	logic [11:0] meas_ff, lp_div_ff, lp_cnt_ff;
	logic in_tol_ff, cal_done_ff, wake_ff;
	logic [7:0] wakes_ff;
	logic [30:0] sleep_cnt_ff;
	wire recal = (wakes_ff == 8'(CAL_EVERY)); // [R7]
	wire [11:0] diff = (meas_ff > rsqd_pkg::LP_DIV_NOM) ? meas_ff - rsqd_pkg::LP_DIV_NOM
		: rsqd_pkg::LP_DIV_NOM - meas_ff;
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			cal_ff <= CAL_ARM; // [R7]
			meas_ff <= 12'h000;
			lp_div_ff <= rsqd_pkg::LP_DIV_NOM;
			in_tol_ff <= 1'b0;
			cal_done_ff <= 1'b0;
		end
		else
		begin
			case (cal_ff)
				CAL_ARM:
					if (low_power_oscillator_tick)
					begin
						meas_ff <= 12'h001;
						cal_ff <= CAL_MEAS;
					end
				CAL_MEAS:
					if (low_power_oscillator_tick)
					begin
						lp_div_ff <= meas_ff; // [R7]
						in_tol_ff <= (diff <= rsqd_pkg::LP_TOL);
						cal_done_ff <= 1'b1;
						cal_ff <= CAL_HOLD;
					end
					else if (meas_ff != 12'hFFF)
						meas_ff <= meas_ff + 12'h001;
				CAL_HOLD:
					if (recal)
						cal_ff <= CAL_ARM;
				default:
					cal_ff <= CAL_ARM;
			endcase
		end
	end
	assign low_power_oscillator_cal_done = cal_done_ff;
	assign low_power_oscillator_in_tol = in_tol_ff;

	// =====================================================================
	// slow tick enable and sleep timer; a zero interval acts as the minimum
	wire lp_en = (lp_cnt_ff >= lp_div_ff - 12'h001); // [R1]
	wire [30:0] ivl_lo = (sleep_ticks < rsqd_pkg::SLEEP_TICKS_MIN) ? rsqd_pkg::SLEEP_TICKS_MIN : sleep_ticks;
	wire [30:0] ivl = (ivl_lo > SLEEP_TICKS_MAX) ? SLEEP_TICKS_MAX : ivl_lo; // [R6]
	wire sleeping = sleep_timer_en && in_sleep;
	wire sleep_hit = sleeping && lp_en && (sleep_cnt_ff >= ivl - 31'h1);
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			lp_cnt_ff <= 12'h000;
			sleep_cnt_ff <= 31'h0;
			wake_ff <= 1'b0;
			wakes_ff <= 8'h00;
		end
		else
		begin
			lp_cnt_ff <= lp_en ? 12'h000 : lp_cnt_ff + 12'h001;
			if (!sleeping || sleep_hit)
				sleep_cnt_ff <= 31'h0;
			else if (lp_en)
				sleep_cnt_ff <= sleep_cnt_ff + 31'h1;
			wake_ff <= sleep_hit; // [R5]
			if (recal)
				wakes_ff <= 8'h00;
			else if (sleep_hit)
				wakes_ff <= wakes_ff + 8'h01;
		end
	end
	assign wake_pulse = wake_ff;

	// =====================================================================
	// strength: two-sample average, then first-order smoothing of set order
	logic [7:0] prev_adc_ff, raw_ff;
	logic [15:0] acc_ff;
	wire [8:0] pair_sum = {1'b0, prev_adc_ff} + {1'b0, rssi_adc};
	wire [15:0] target = {pair_sum[8:1], 8'h00};
	wire [15:0] step_up = (target - acc_ff) >> rssi_cfg.smooth_order; // [R9]
	wire [15:0] step_dn = (acc_ff - target) >> rssi_cfg.smooth_order;
	wire [15:0] nxt_acc = (target >= acc_ff) ? acc_ff + step_up : acc_ff - step_dn;
	wire live = (rssi_cfg.capture_select != rsqd_pkg::CAP_PKT_STAGE);
	wire take_raw = live ? rssi_adc_valid : pkt_stage; // [R11]
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			prev_adc_ff <= BYTE_RST_W;
			acc_ff <= rsqd_pkg::ACC_RST;
			raw_ff <= BYTE_RST_W;
		end
		else
		begin
			if (rssi_adc_valid)
			begin
				prev_adc_ff <= rssi_adc;
				acc_ff <= nxt_acc;
			end
			if (take_raw)
				raw_ff <= acc_ff[15:8]; // [R10]
		end
	end
	assign strength_raw_code = raw_ff;
	assign strength_in_dbm = raw_ff - rsqd_pkg::DBM_OFFSET; // [R10]
	assign strength_above = (raw_ff > rssi_cfg.threshold); // [R12]

	// =====================================================================
	// phase-jump detector: for symbol_len below 128, a transition counts only if spaced from three quarters of a symbol up to four symbols
	logic last_bit_ff, pjd_ff;
	logic [8:0] run_ff;
	logic [4:0] jumps_ff;
	wire [8:0] sym = {1'b0, pjd_cfg.symbol_len};
	wire jump = fsk_active && demod_valid && (demod_bit != last_bit_ff); // [R14]
	wire rate_ok = (run_ff + 9'h001 >= sym - (sym >> 2)) && (run_ff < (sym << 2));
	wire quality_ok = demod_err_ok && (snr_db > rsqd_pkg::SNR_MIN_DB); // [R17]
	wire win_full = (jumps_ff + 5'h01 >= rsqd_pkg::jump_target(pjd_cfg.window_select)); // [R15]
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			last_bit_ff <= 1'b0;
			pjd_ff <= 1'b0;
			run_ff <= 9'h000;
			jumps_ff <= 5'h00;
		end
		else if (!fsk_active)
		begin
			pjd_ff <= 1'b0;
			run_ff <= 9'h000;
			jumps_ff <= 5'h00;
		end
		else if (demod_valid)
		begin
			last_bit_ff <= demod_bit;
			run_ff <= jump ? 9'h000 : (run_ff == 9'h1FF ? run_ff : run_ff + 9'h001);
			if (jump && !rate_ok)
			begin
				jumps_ff <= 5'h00;
				pjd_ff <= 1'b0; // [R17]
			end
			else if (jump && win_full)
			begin
				jumps_ff <= 5'h00;
				pjd_ff <= quality_ok; // [R17]
			end
			else if (jump)
				jumps_ff <= jumps_ff + 5'h01;
		end
	end
	assign phase_jump_detector = pjd_ff;

	// =====================================================================
	// result routing
	assign signal_valid_irq = (strength_above && rssi_cfg.route == rsqd_pkg::ROUTE_IRQ) // [R13]
		|| (pjd_ff && pjd_cfg.route == rsqd_pkg::ROUTE_IRQ); // [R18]
	assign super_low_power_rx = (strength_above && rssi_cfg.route == rsqd_pkg::ROUTE_SLP) // [R13]
		|| (pjd_ff && pjd_cfg.route == rsqd_pkg::ROUTE_SLP); // [R18]

	// =====================================================================
	// checks
	a_mute_silences_out: assert property (@(posedge clk_sys) disable iff (!resetn) // [R19]
		demod_valid && pass_through && dout_mute && !pjd_ff |=> !dout_ff) else $error("muted output high");
	a_dout_only_direct: assert property (@(posedge clk_sys) disable iff (!resetn) // [R2]
		!pass_through |-> gpio_oe == 3'h0) else $error("pin driven in packet mode");
	a_lbd_tune_capture: assert property (@(posedge clk_sys) disable iff (!resetn) // [R8]
		tune_evt |=> battery_level_result == $past(battery_sample)) else $error("battery not captured");
	a_lbd_holds_value: assert property (@(posedge clk_sys) disable iff (!resetn) // [R20]
		!tune_evt |=> $stable(battery_level_result)) else $error("battery result changed");
	a_wake_needs_enable: assert property (@(posedge clk_sys) disable iff (!resetn) // [R5]
		wake_pulse |-> $past(sleep_timer_en && in_sleep)) else $error("wake without enable");
	a_pjd_needs_fsk: assert property (@(posedge clk_sys) disable iff (!resetn) // [R14]
		!fsk_active |=> !phase_jump_detector) else $error("judgement outside fsk");
	a_pjd_snr_gate: assert property (@(posedge clk_sys) disable iff (!resetn) // [R17]
		$rose(phase_jump_detector) |-> $past(snr_db) > 8'h07) else $error("judgement with low snr");
	a_above_compare: assert property (@(posedge clk_sys) disable iff (!resetn) // [R12]
		take_raw && acc_ff[15:8] > rssi_cfg.threshold && $stable(rssi_cfg) |=> strength_above)
		else $error("compare flag missing");
	c_wake_seen: cover property (@(posedge clk_sys) disable iff (!resetn) wake_pulse);
	c_pjd_valid: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(phase_jump_detector));
	c_fifo_full: cover property (@(posedge clk_sys) disable iff (!resetn) !fifo_in_ready ##1 pkt_overflow);
endmodule

//--- sim/rsqd_ctrl_model.sv
/*
 * controller side of the packet path: reads buffered bytes at a random pace.
 * assumes the pkt_* ports of the receive block, all on clk_sys.
 */
`timescale 1ns/1ps
// =====================================================================
// byte reader
module rsqd_ctrl_model (
	input wire logic clk_sys, // system clock
	input wire logic resetn, // reset, low
	input wire logic [7:0] pkt_data, // head byte
	input wire logic pkt_valid, // byte waiting
	output logic pkt_ready, // take byte
	input wire logic stall // hold off reads
);
	logic [7:0] got[$];
	int seed = 32'h127ADBD2;
	// ready wanders at random so pops land on odd cycles; stall models a busy controller
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			pkt_ready <= 1'b0;
			got.delete(); // forget everything and start over
		end
		else
		begin
			if (pkt_valid && pkt_ready)
				got.push_back(pkt_data); // byte retrieved
			pkt_ready <= !stall && $random(seed) & 1;
		end
	end
endmodule

//--- sim/rx_signal_quality_detect_test.sv
/*
 * self-checking bench for the receive quality block.
 * assumes rsqd_pkg, the design and the controller model are compiled first.
 */
`timescale 1ns/1ps
module rx_signal_quality_detect_test;
	localparam logic [30:0] SLP_MAX = 31'h0000_0004;
	logic clk_sys = 1'b0, resetn = 1'b0, stall = 1'b0, cur = 1'b0, b, r;
	logic demod_bit = 1'b0, demod_valid = 1'b0, fsk_active = 1'b0, pass_through = 1'b0;
	logic [1:0] dout_sel = 2'h0;
	logic dout_mute = 1'b0, pkt_ready, pkt_valid, pkt_overflow, pkt_overflow_clr = 1'b0;
	logic [2:0] gpio_out, gpio_oe;
	logic [7:0] pkt_data, battery_level_result, strength_raw_code, strength_in_dbm, v, s, exp_bat;
	logic [7:0] battery_sample = 8'h00, rssi_adc = 8'h00, snr_db = 8'h00, sent[18];
	logic [3:0] chip_state = 4'h0;
	logic sleep_timer_en = 1'b0, in_sleep = 1'b0, wake_pulse, low_power_oscillator_tick = 1'b0;
	logic [30:0] sleep_ticks = 31'h0, ivs[2] = '{31'h0000_0000, 31'h0000_0007};
	logic low_power_oscillator_cal_done, low_power_oscillator_in_tol, rssi_adc_valid = 1'b0, pkt_stage = 1'b0;
	logic strength_above, demod_err_ok = 1'b0, phase_jump_detector, signal_valid_irq, super_low_power_rx;
	rsqd_pkg::rsqd_rssi_cfg_t rssi_cfg = '0;
	rsqd_pkg::rsqd_pjd_cfg_t pjd_cfg = '0;
	logic [3:0] froms[4] = '{rsqd_pkg::ST_SLEEP, rsqd_pkg::ST_STANDBY_STATE, rsqd_pkg::ST_IDLE, rsqd_pkg::ST_RX};
	int cw[5] = '{1, 1, 0, 2, 3}, cs[5] = '{7, 8, 8, 8, 8}, cok[5] = '{1, 0, 1, 1, 1};
	int pers[2] = '{3200, 3125};
	int miscompares = 0, n_tests = 0, seed = 32'h127ADBD2, lp_per = 3125, lp_cnt = 0, i, k, tgt;
	logic tick_on = 1'b0;

	rsqd_rx_quality #(.SLEEP_TICKS_MAX(SLP_MAX), .CAL_EVERY(2)) i_rsqd_rx_quality (
		.clk_sys(clk_sys), .resetn(resetn), .demod_bit(demod_bit), .demod_valid(demod_valid),
		.fsk_active(fsk_active), .pass_through(pass_through), .dout_sel(dout_sel), .dout_mute(dout_mute),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .pkt_data(pkt_data), .pkt_valid(pkt_valid),
		.pkt_ready(pkt_ready), .pkt_overflow(pkt_overflow), .pkt_overflow_clr(pkt_overflow_clr),
		.chip_state(chip_state), .battery_sample(battery_sample), .battery_level_result(battery_level_result),
		.sleep_timer_en(sleep_timer_en), .sleep_ticks(sleep_ticks), .in_sleep(in_sleep), .wake_pulse(wake_pulse),
		.low_power_oscillator_tick(low_power_oscillator_tick), .low_power_oscillator_cal_done(low_power_oscillator_cal_done), .low_power_oscillator_in_tol(low_power_oscillator_in_tol),
		.rssi_adc(rssi_adc), .rssi_adc_valid(rssi_adc_valid), .rssi_cfg(rssi_cfg), .pkt_stage(pkt_stage),
		.strength_raw_code(strength_raw_code), .strength_in_dbm(strength_in_dbm),
		.strength_above(strength_above), .pjd_cfg(pjd_cfg), .demod_err_ok(demod_err_ok), .snr_db(snr_db),
		.phase_jump_detector(phase_jump_detector), .signal_valid_irq(signal_valid_irq),
		.super_low_power_rx(super_low_power_rx)
	);
	rsqd_ctrl_model i_rsqd_ctrl_model (
		.clk_sys(clk_sys), .resetn(resetn), .pkt_data(pkt_data), .pkt_valid(pkt_valid),
		.pkt_ready(pkt_ready), .stall(stall)
	);

	// =====================================================================
	// clock and slow oscillator ticks; the tick period is ours to skew
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		lp_cnt <= (lp_cnt >= lp_per - 1) ? 0 : lp_cnt + 1;
		low_power_oscillator_tick <= tick_on && lp_cnt == lp_per - 1;
	end

	// =====================================================================
	// expectations and helpers
	function automatic logic [2:0] oe_of(logic [1:0] sel);
		return (sel == 2'h0) ? 3'h0 : 3'(3'h1 << (sel - 2'h1));
	endfunction
	function automatic int exp_wake(logic [30:0] t);
		return (t == 31'h0) ? 3125 : ((t > SLP_MAX) ? int'(SLP_MAX) * 3125 : int'(t) * 3125);
	endfunction
	function automatic logic exp_pjd(int snr, int ok);
		return snr > 7 && ok != 0;
	endfunction
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// every wait ends one ns past an edge so outputs have settled
	task automatic cyc(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic await(ref logic sig, input logic lv, input int lim, output int cnt);
		cnt = 0;
		while (sig !== lv)
		begin
			if (cnt == lim)
			begin
				miscompares++;
				$display("MISMATCH wait expected %b seen timeout", lv);
				summarize();
			end
			cyc(1);
			cnt++;
		end
	endtask
	task automatic do_reset;
		resetn <= 1'b0;
		cyc(6);
		chk("reset outputs", 0, {battery_level_result, wake_pulse, pkt_valid, pkt_overflow, low_power_oscillator_cal_done,
			low_power_oscillator_in_tol, strength_raw_code, phase_jump_detector});
		resetn <= 1'b1;
		cyc(1);
	endtask
	// strobes held high back to back, msb first; a trailing edge keeps drivers apart
	task automatic bits(logic [15:0] val, int n);
		for (int j = n - 1; j >= 0; j--)
		begin
			demod_bit <= val[j];
			demod_valid <= 1'b1;
			@(posedge clk_sys);
		end
		demod_valid <= 1'b0;
		cyc(1);
	endtask
	task automatic jumps(int n);
		repeat (n)
		begin
			bits({16{cur}}, 8);
			cur = ~cur;
		end
	endtask
	task automatic feed(logic [7:0] val, int n);
		rssi_adc <= val;
		rssi_adc_valid <= 1'b1;
		cyc(n);
		rssi_adc_valid <= 1'b0;
		cyc(1);
	endtask

	// =====================================================================
	// main sequence
	initial
	begin
		do_reset();
		pass_through <= 1'b1;
		for (i = 0; i < 16; i++)
		begin
			dout_sel <= 2'(i / 4);
			b = $random(seed);
			bits(16'(b), 1);
			chk("pin enable", oe_of(2'(i / 4)), gpio_oe);
			chk("pin data", b ? oe_of(2'(i / 4)) : 3'h0, gpio_out);
		end
		dout_mute <= 1'b1;
		dout_sel <= 2'h1;
		bits(16'h0001, 1);
		chk("muted pin", 0, gpio_out);
		$display("end of direct path, mismatches %0d", miscompares);
		// packet bytes pile up behind a stalled reader until one is lost
		do_reset();
		pass_through <= 1'b0;
		stall <= 1'b1;
		cyc(1);
		chk("pin enable off", 0, gpio_oe);
		for (i = 0; i < 18; i++)
		begin
			sent[i] = $random(seed);
			bits(16'(sent[i]), 8);
			cyc(3);
			chk("overflow flag", i == 17, pkt_overflow);
		end
		pkt_overflow_clr <= 1'b1;
		cyc(1);
		pkt_overflow_clr <= 1'b0;
		cyc(1);
		chk("overflow cleared", 0, pkt_overflow);
		stall <= 1'b0;
		await(pkt_valid, 1'b0, 400, k);
		cyc(2);
		chk("bytes read", 17, i_rsqd_ctrl_model.got.size());
		for (i = 0; i < 17; i++)
			chk("byte order", sent[i], i_rsqd_ctrl_model.got[i]);
		$display("end of packet path, mismatches %0d", miscompares);
		// battery result follows tuning moves only, and holds otherwise
		exp_bat = 8'h00;
		for (i = 0; i < 8; i++)
		begin
			chip_state <= froms[i % 4];
			cyc(2);
			s = $random(seed);
			chip_state <= 4'(rsqd_pkg::ST_RFS + 4'(i % 4));
			battery_sample <= s;
			cyc(3);
			exp_bat = (i % 4 < 2) ? s : exp_bat;
			battery_sample <= ~s;
			cyc(2);
			chk("battery result", exp_bat, battery_level_result);
		end
		$display("end of battery, mismatches %0d", miscompares);
		// step response shows the smoothing order; then compare and routing
		do_reset();
		for (i = 0; i < 2; i++)
		begin
			rssi_cfg <= '{smooth_order: (i == 0) ? 3'h7 : 3'h0, capture_select: rsqd_pkg::CAP_REALTIME,
				threshold: 8'hFF, route: rsqd_pkg::ROUTE_IRQ};
			feed(8'hF0, 6);
			chk("step response", i, strength_raw_code == 8'hF0);
		end
		v = $random(seed);
		v = (v == 8'h00) ? 8'h01 : v;
		feed(v, 20);
		chk("raw code", v, strength_raw_code);
		chk("dbm value", 8'(v - rsqd_pkg::DBM_OFFSET), strength_in_dbm);
		rssi_cfg.threshold <= v - 8'h01;
		cyc(1);
		chk("above flag", 1, strength_above);
		chk("irq route", 2'b10, {signal_valid_irq, super_low_power_rx});
		rssi_cfg.route <= rsqd_pkg::ROUTE_SLP;
		cyc(1);
		chk("slp route", 2'b01, {signal_valid_irq, super_low_power_rx});
		rssi_cfg.threshold <= v;
		cyc(1);
		chk("equal not above", 0, strength_above);
		rssi_cfg.capture_select <= rsqd_pkg::CAP_PKT_STAGE;
		feed(~v, 20);
		chk("held code", v, strength_raw_code);
		pkt_stage <= 1'b1;
		cyc(1);
		pkt_stage <= 1'b0;
		cyc(2);
		chk("captured code", 8'(~v), strength_raw_code);
		$display("end of strength, mismatches %0d", miscompares);
		// jump detector: window 1 asks for four jumps, the usual choice
		do_reset();
		pass_through <= 1'b1;
		dout_mute <= 1'b1;
		for (i = 0; i < 5; i++)
		begin
			tgt = 2 << cw[i];
			cur = 1'b0;
			pjd_cfg <= '{window_select: 2'(cw[i]), symbol_len: 8'h08, route: i[0]};
			snr_db <= 8'(cs[i]);
			demod_err_ok <= cok[i][0];
			fsk_active <= 1'b1;
			cyc(1);
			jumps(tgt);
			chk("early judgement", 0, phase_jump_detector);
			jumps(3);
			r = exp_pjd(cs[i], cok[i]);
			chk("judgement", r, phase_jump_detector);
			chk("jump irq route", i[0] ? 1'b0 : r, signal_valid_irq);
			chk("jump slp route", i[0] ? r : 1'b0, super_low_power_rx);
			bits(16'h0001, 1);
			chk("gated pin", {2'b00, r}, gpio_out);
			bits(16'h0000, 1);
			fsk_active <= 1'b0;
			cyc(2);
		end
		$display("end of jump detector, mismatches %0d", miscompares);
		// slow oscillator measured once ticks run; then wake spacing
		foreach (pers[j])
		begin
			tick_on = 1'b0;
			lp_per = pers[j];
			do_reset();
			tick_on = 1'b1;
			await(low_power_oscillator_cal_done, 1'b1, 4 * 3200, k);
			chk("in tolerance", pers[j] == 3125, low_power_oscillator_in_tol);
		end
		sleep_timer_en <= 1'b1;
		in_sleep <= 1'b1;
		foreach (ivs[j])
		begin
			sleep_ticks <= ivs[j];
			await(wake_pulse, 1'b1, 40000, k);
			cyc(1);
			chk("wake pulse width", 0, wake_pulse);
			await(wake_pulse, 1'b1, 40000, k);
			chk("wake interval", exp_wake(ivs[j]), k + 1);
		end
		$display("end of sleep timer, mismatches %0d", miscompares);
		summarize();
	end
endmodule
